// ===== hw/attr_record.sv
// packs one twelve-byte attribute record, lowest byte first
module attr_record
  import smart_pkg::*;
(
  input  wire logic [7:0]  id,
  input  wire logic [15:0] flags,
  input  wire logic [7:0]  value,
  input  wire logic [63:0] payload,
  output record_t          rec
);

  // byte 0 id, 1..2 flags, 3 value, 4..11 payload
  assign rec = {payload, value, flags, id};
endmodule

// ===== hw/smart_attribute_reporter.sv
// health attribute records, threshold sector and return-status reply
`include "smart_defines.svh"

module smart_attribute_reporter
  import smart_pkg::*;
#(
  parameter int ERASE_TARGET = `ERASE_TARGET
)
(
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          cmd_valid,
  input  wire taskfile_t                     cmd,
  input  wire counts_t                       counts,
  input  wire logic [`SPARE_CHIPS-1:0][15:0] spare_init,
  input  wire logic [`SPARE_CHIPS-1:0][15:0] spare_cur,
  input  wire logic [7:0]                    spare_thr,
  input  wire logic [7:0]                    erase_thr,
  input  wire logic                          out_ready,
  output logic                               busy,
  output logic                               out_valid,
  output logic [7:0]                         out_byte,
  output logic                               out_last,
  output logic                               status_valid,
  output logic [7:0]                         status_cyl_lo,
  output logic [7:0]                         status_cyl_hi
);

  // ************************************************
  // command decode
  // ************************************************
  logic        sig_ok;
  logic        take;
  logic        start_data;
  logic        start_thr;
  logic        start_stat;
  assign sig_ok     = cmd.command == `CMD_RELIABILITY && cmd.cyl_lo == `CYL_LO_OK
                      && cmd.cyl_hi == `CYL_HI_OK;
  assign take       = cmd_valid && !busy && sig_ok;
  assign start_data = take && cmd.features == `FEAT_READ_DATA;
  assign start_thr  = take && cmd.features == `FEAT_READ_THRESH;
  assign start_stat = take && cmd.features == `FEAT_RET_STATUS;

  // ************************************************
  // spare block percentage, minimum over chips
  // ************************************************
  logic [7:0]  chip_pct [`SPARE_CHIPS];
  logic [7:0]  min_pct  [`SPARE_CHIPS+1];
  logic [15:0] min_init [`SPARE_CHIPS+1];
  logic [15:0] min_cur  [`SPARE_CHIPS+1];
  logic [15:0] sum_init [`SPARE_CHIPS+1];
  logic [15:0] sum_cur  [`SPARE_CHIPS+1];
  assign min_pct[0]  = 8'(`PCT_FULL);
  assign min_init[0] = 16'h0000;
  assign min_cur[0]  = 16'h0000;
  assign sum_init[0] = 16'h0000;
  assign sum_cur[0]  = 16'h0000;
  for (genvar c = 0; c < `SPARE_CHIPS; c++) begin : g_chip
    logic [31:0] scaled;
    logic [31:0] ratio;
    assign scaled = 32'(spare_cur[c]) * 32'(`PCT_FULL);
    assign ratio  = (spare_init[c] == 16'h0000) ? 32'(`PCT_FULL) : scaled / 32'(spare_init[c]);
    // a chip with more spares than at start still counts as full
    assign chip_pct[c] = (ratio > 32'(`PCT_FULL)) ? 8'(`PCT_FULL) : ratio[7:0];
    // keep the chip with the lowest percentage
    assign min_pct[c+1]  = (c == 0 || chip_pct[c] < min_pct[c]) ? chip_pct[c] : min_pct[c];
    assign min_init[c+1] = (c == 0 || chip_pct[c] < min_pct[c]) ? spare_init[c] : min_init[c];
    assign min_cur[c+1]  = (c == 0 || chip_pct[c] < min_pct[c]) ? spare_cur[c] : min_cur[c];
    assign sum_init[c+1] = 16'(sum_init[c] + spare_init[c]);
    assign sum_cur[c+1]  = 16'(sum_cur[c] + spare_cur[c]);
  end

  // ************************************************
  // remaining life estimate and threshold check
  // ************************************************
  logic [7:0]  spare_val;
  logic [7:0]  life_val;
  logic [63:0] used_pct;
  logic        exceeded;
  assign spare_val = min_pct[`SPARE_CHIPS];
  assign used_pct  = (64'(counts.erase_avg) * 64'(`PCT_FULL)) / 64'(ERASE_TARGET);
  assign life_val  = (used_pct >= 64'(`PCT_FULL)) ? 8'h00
                     : 8'(64'(`PCT_FULL) - used_pct);
  // only spare and erase values take part in the verdict
  assign exceeded  = (spare_val < spare_thr) || (life_val < erase_thr);

  // ************************************************
  // snapshot of everything a sector reports
  // ************************************************
  counts_t     snap;
  logic [7:0]  snap_spare;
  logic [7:0]  snap_life;
  logic [63:0] snap_spare_pay;
  logic [7:0]  snap_spare_thr;
  logic [7:0]  snap_erase_thr;
  always_ff @(posedge clk) begin
    if (start_data || start_thr) begin
      snap           <= counts;
      snap_spare     <= spare_val;
      snap_life      <= life_val;
      snap_spare_pay <= {sum_cur[`SPARE_CHIPS], sum_init[`SPARE_CHIPS],
                         min_cur[`SPARE_CHIPS], min_init[`SPARE_CHIPS]};
      snap_spare_thr <= spare_thr;
      snap_erase_thr <= erase_thr;
    end
  end

  // ************************************************
  // attribute records
  // ************************************************
  logic [7:0]  rec_id    [`REC_COUNT];
  logic [15:0] rec_flags [`REC_COUNT];
  logic [7:0]  rec_value [`REC_COUNT];
  logic [63:0] rec_pay   [`REC_COUNT];
  logic [7:0]  rec_thr   [`REC_COUNT];
  record_t     rec       [`REC_COUNT];
  assign rec_id[0]    = `ID_SPARE;
  assign rec_flags[0] = `FLAGS_PREFAIL;
  assign rec_value[0] = snap_spare;
  assign rec_pay[0]   = snap_spare_pay;
  assign rec_thr[0]   = snap_spare_thr;
  assign rec_id[1]    = `ID_ERASE;
  assign rec_flags[1] = `FLAGS_ADVISORY;
  assign rec_value[1] = snap_life;
  assign rec_pay[1]   = snap.erase_total;
  assign rec_thr[1]   = snap_erase_thr;
  // fixed-value records, upper four payload bytes zero except the reads record
  assign rec_id[2]    = `ID_ECC_TOTAL;
  assign rec_pay[2]   = {32'h0000_0000, snap.ecc_total};
  assign rec_id[3]    = `ID_ECC_CORR;
  assign rec_pay[3]   = {32'h0000_0000, snap.ecc_corr};
  assign rec_id[4]    = `ID_READS;
  assign rec_pay[4]   = snap.reads;
  assign rec_id[5]    = `ID_UDMA_CRC;
  assign rec_pay[5]   = {32'h0000_0000, snap.udma_crc};
  for (genvar r = 0; r < `REC_COUNT; r++) begin : g_rec
    if (r >= 2) begin : g_fixed
      assign rec_flags[r] = `FLAGS_ADVISORY;
      assign rec_value[r] = `VALUE_FIXED;
      assign rec_thr[r]   = 8'h00;
    end
    attr_record u_rec (
      .id      (rec_id[r]),
      .flags   (rec_flags[r]),
      .value   (rec_value[r]),
      .payload (rec_pay[r]),
      .rec     (rec[r])
    );
  end

  // ************************************************
  // sector byte tables
  // ************************************************
  logic [7:0] data_tab [`SECTOR_BYTES];
  logic [7:0] thr_tab  [`SECTOR_BYTES];
  for (genvar k = 0; k < `SECTOR_BYTES; k++) begin : g_byte
    if (k < `SLOT_BASE) begin : g_ver
      assign data_tab[k] = 8'(`STRUCT_VERSION >> (8 * k));
      assign thr_tab[k]  = 8'(`STRUCT_VERSION >> (8 * k));
    end else if (k < `SLOT_BASE + `REC_COUNT * `SLOT_BYTES) begin : g_slot
      localparam int S = (k - `SLOT_BASE) / `SLOT_BYTES;
      localparam int B = (k - `SLOT_BASE) % `SLOT_BYTES;
      assign data_tab[k] = rec[S][B*8 +: 8];
      if (B == 0) begin : g_id
        assign thr_tab[k] = rec[S][7:0];
      end else if (B == 1) begin : g_thr
        assign thr_tab[k] = rec_thr[S];
      end else begin : g_res
        assign thr_tab[k] = 8'h00;
      end
    end else if (k == `CAPS_OFFSET || k == `CAPS_OFFSET + 1) begin : g_caps
      assign data_tab[k] = 8'(`CAPS_VALUE >> (8 * (k - `CAPS_OFFSET)));
      assign thr_tab[k]  = 8'h00;
    end else if (k == `VENDOR_VER_OFFSET || k == `VENDOR_VER_OFFSET + 1) begin : g_vver
      assign data_tab[k] = 8'(`VENDOR_VER_VALUE >> (8 * (k - `VENDOR_VER_OFFSET)));
      assign thr_tab[k]  = 8'h00;
    end else begin : g_zero
      // unused slots up to thirty and reserved area
      assign data_tab[k] = 8'h00;
      assign thr_tab[k]  = 8'h00;
    end
  end

  // ************************************************
  // byte streamer
  // ************************************************
  mode_t      mode;
  logic [8:0] idx;
  logic [7:0] sum;
  logic [7:0] next_byte;
  logic       advance;
  logic       accept;
  assign advance   = mode != MODE_IDLE && (!out_valid || out_ready);
  assign accept    = out_valid && out_ready;
  // final byte makes the whole sector sum to zero
  assign next_byte = (idx == `LAST_INDEX) ? 8'(8'h00 - sum)
                     : (mode == MODE_THRESH) ? thr_tab[idx] : data_tab[idx];

  // sequencing of one sector
  always_ff @(posedge clk) begin
    if (srst) begin
      mode <= MODE_IDLE;
      idx  <= 9'h000;
      sum  <= 8'h00;
      busy <= 1'b0;
    end else if (start_data || start_thr) begin
      mode <= start_thr ? MODE_THRESH : MODE_DATA;
      idx  <= 9'h000;
      sum  <= 8'h00;
      busy <= 1'b1;
    end else begin
      if (advance) begin
        idx  <= 9'(idx + 9'h001);
        sum  <= 8'(sum + next_byte);
        mode <= (idx == `LAST_INDEX) ? MODE_IDLE : mode;
      end
      if (accept && out_last) begin
        busy <= 1'b0;
      end
    end
  end

  // output holding register
  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_byte  <= 8'h00;
      out_last  <= 1'b0;
    end else if (advance) begin
      out_valid <= 1'b1;
      out_byte  <= next_byte;
      out_last  <= idx == `LAST_INDEX;
    end else if (accept) begin
      out_valid <= 1'b0;
      out_last  <= 1'b0;
    end
  end

  // ************************************************
  // return-status reply
  // ************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      status_valid  <= 1'b0;
      status_cyl_lo <= 8'h00;
      status_cyl_hi <= 8'h00;
    end else begin
      status_valid <= start_stat;
      if (start_stat) begin
        status_cyl_lo <= exceeded ? `CYL_LO_BAD : `CYL_LO_OK;
        status_cyl_hi <= exceeded ? `CYL_HI_BAD : `CYL_HI_OK;
      end
    end
  end

  // ************************************************
  // checks
  // ************************************************
  logic [9:0] acc_cnt;
  always_ff @(posedge clk) begin
    if (srst || start_data || start_thr) begin
      acc_cnt <= 10'h000;
    end else if (accept) begin
      acc_cnt <= 10'(acc_cnt + 10'h001);
    end
  end

  sequence thr_cmd_s;
    start_thr;
  endsequence
  sequence version_first_s;
    ##[1:2] (out_valid && out_byte == 8'h04);
  endsequence

  status_bad_a: assert property (@(posedge clk) disable iff (srst)
    start_stat && exceeded |=> status_valid && status_cyl_lo == `CYL_LO_BAD
                               && status_cyl_hi == `CYL_HI_BAD)
    else $error("bad status reply wrong");
  status_ok_a: assert property (@(posedge clk) disable iff (srst)
    start_stat && !exceeded |=> status_valid && status_cyl_lo == `CYL_LO_OK
                                && status_cyl_hi == `CYL_HI_OK)
    else $error("good status reply wrong");
  spare_exceed_a: assert property (@(posedge clk) disable iff (srst)
    start_stat && spare_val < spare_thr |=> status_cyl_lo == `CYL_LO_BAD
                                            && status_cyl_hi == `CYL_HI_BAD)
    else $error("spare threshold missed");
  erase_exceed_a: assert property (@(posedge clk) disable iff (srst)
    start_stat && life_val < erase_thr |=> status_cyl_lo == `CYL_LO_BAD
                                           && status_cyl_hi == `CYL_HI_BAD)
    else $error("erase threshold missed");
  status_only_a: assert property (@(posedge clk) disable iff (srst)
    start_stat && spare_val >= spare_thr && life_val >= erase_thr
    |=> status_cyl_lo == `CYL_LO_OK && status_cyl_hi == `CYL_HI_OK)
    else $error("status raised by other attribute");
  fixed_tail_a: assert property (@(posedge clk) disable iff (srst)
    rec[2][31:24] == `VALUE_FIXED && rec[5][95:64] == 32'h0000_0000
    && rec[3][23:8] == `FLAGS_ADVISORY)
    else $error("fixed record fields wrong");
  thr_version_a: assert property (@(posedge clk) disable iff (srst)
    thr_cmd_s |-> version_first_s)
    else $error("threshold sector start wrong");
  sector_len_a: assert property (@(posedge clk) disable iff (srst)
    out_valid && out_last |-> acc_cnt == 10'h1FF)
    else $error("sector length wrong");
  stall_hold_a: assert property (@(posedge clk) disable iff (srst)
    out_valid && !out_ready |=> out_valid && $stable(out_byte) && $stable(out_last))
    else $error("byte changed under stall");
  busy_refuse_a: assert property (@(posedge clk) disable iff (srst)
    busy && cmd_valid |=> !status_valid && ($stable(mode) || mode == MODE_IDLE))
    else $error("command taken while busy");
endmodule

// ===== pkg/smart_defines.svh
// constants for the health attribute reporter
`ifndef SMART_DEFINES_SVH
`define SMART_DEFINES_SVH

// ************************************************
// task-file command decode
// ************************************************
`define CMD_RELIABILITY   8'hB0
`define FEAT_READ_DATA    8'hD0
`define FEAT_READ_THRESH  8'hD1
`define FEAT_RET_STATUS   8'hDA
`define CYL_LO_OK         8'h4F
`define CYL_HI_OK         8'hC2
`define CYL_LO_BAD        8'hF4
`define CYL_HI_BAD        8'h2C

// ************************************************
// attribute identifiers, flags and fixed values
// ************************************************
`define ID_SPARE          8'hC4
`define ID_ERASE          8'hE5
`define ID_ECC_TOTAL      8'hCB
`define ID_ECC_CORR       8'hCC
`define ID_READS          8'hE8
`define ID_UDMA_CRC       8'hC7
`define FLAGS_PREFAIL     16'h0003
`define FLAGS_ADVISORY    16'h0002
`define VALUE_FIXED       8'h64
`define PCT_FULL          100

// ************************************************
// sector layout
// ************************************************
`define SLOT_BASE         2
`define SLOT_BYTES        12
`define SLOT_COUNT        30
`define REC_COUNT         6
`define SECTOR_BYTES      512
`define LAST_INDEX        9'h1FF
`define STRUCT_VERSION    16'h0004
`define CAPS_OFFSET       368
`define CAPS_VALUE        16'h0003
`define VENDOR_VER_OFFSET 386
`define VENDOR_VER_VALUE  16'h0002
`define SPARE_CHIPS       4
`define ERASE_TARGET      100000

`endif

// ===== pkg/smart_pkg.sv
// types shared by the health attribute reporter
package smart_pkg;

  // ************************************************
  // carriers
  // ************************************************
  typedef struct packed {
    logic [7:0] command;
    logic [7:0] features;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
  } taskfile_t;

  typedef struct packed {
    logic [31:0] erase_avg;
    logic [63:0] erase_total;
    logic [31:0] ecc_total;
    logic [31:0] ecc_corr;
    logic [63:0] reads;
    logic [31:0] udma_crc;
  } counts_t;

  typedef logic [95:0] record_t;

  typedef enum logic [1:0] {
    MODE_IDLE   = 2'b00,
    MODE_DATA   = 2'b01,
    MODE_THRESH = 2'b10
  } mode_t;

endpackage

// ===== sim/ata_host_model.sv
// host controller model: issues task-file commands and drains sector stream
module ata_host_model
  import smart_pkg::*;
(
  input  wire logic       clk,
  output logic            cmd_valid,
  output taskfile_t       cmd,
  output logic            out_ready,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_byte,
  input  wire logic       out_last
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] sector [0:511];
  int         n_got;
  int         last_at;
  int         hold_err;
  logic       held;
  logic [7:0] held_byte;

  // idle levels at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    out_ready = 1'b0;
  end

  // ************************
  // command and stream tasks
  // ************************
  // one-cycle strobe, fields scrambled once released
  task automatic send(input logic [7:0] op, input logic [7:0] feat,
                      input logic [7:0] lo, input logic [7:0] hi);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{command: op, features: feat, cyl_lo: lo, cyl_hi: hi};
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd = ~cmd;
  endtask

  // drain one sector; stall draws random ready levels, bytes must hold
  task automatic collect(input bit stall);
    int guard;
    n_got = 0;
    last_at = -1;
    hold_err = 0;
    held = 1'b0;
    guard = 0;
    while (last_at < 0 && guard < 4000) begin
      @(negedge clk);
      guard++;
      if (held && out_byte !== held_byte) begin
        hold_err++;
      end
      out_ready = stall ? 1'($urandom_range(0, 1)) : 1'b1;
      held = out_valid & ~out_ready;
      held_byte = out_byte;
      if (out_valid && out_ready) begin
        if (n_got < 512) begin
          sector[n_got] = out_byte;
        end
        if (out_last) begin
          last_at = n_got;
        end
        n_got++;
      end
    end
    @(negedge clk);
    out_ready = 1'b0;
  endtask
endmodule

// ===== sim/smart_attribute_reporter_bench.sv
// self-checking bench for the health attribute reporter
`include "smart_defines.svh"

module smart_attribute_reporter_bench
  import smart_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int TARGET = 100;

  logic                          clk;
  logic                          srst;
  logic                          cmd_valid;
  taskfile_t                     cmd;
  counts_t                       counts;
  logic [`SPARE_CHIPS-1:0][15:0] spare_init;
  logic [`SPARE_CHIPS-1:0][15:0] spare_cur;
  logic [7:0]                    spare_thr;
  logic [7:0]                    erase_thr;
  logic                          out_ready;
  logic                          busy;
  logic                          out_valid;
  logic [7:0]                    out_byte;
  logic                          out_last;
  logic                          status_valid;
  logic [7:0]                    status_cyl_lo;
  logic [7:0]                    status_cyl_hi;
  logic [7:0]                    exp_sec [0:511];
  int                            n_mismatch;
  int                            samples_checked;
  int                            n_status;
  int                            n0;
  int                            cycles;

  // ************************
  // design and host model
  // ************************
  smart_attribute_reporter #(.ERASE_TARGET(TARGET)) dut_u (
    .clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd), .counts(counts),
    .spare_init(spare_init), .spare_cur(spare_cur), .spare_thr(spare_thr),
    .erase_thr(erase_thr), .out_ready(out_ready), .busy(busy), .out_valid(out_valid),
    .out_byte(out_byte), .out_last(out_last), .status_valid(status_valid),
    .status_cyl_lo(status_cyl_lo), .status_cyl_hi(status_cyl_hi));

  ata_host_model host_u (
    .clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .out_ready(out_ready),
    .out_valid(out_valid), .out_byte(out_byte), .out_last(out_last));

  // clock source
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // reply counter and hang guard
  always @(posedge clk) begin
    cycles++;
    if (status_valid === 1'b1) n_status++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ************************
  // expectation helpers
  // ************************
  function automatic int chip_pct(int i);
    int p;
    if (spare_init[i] == 16'h0000) return 100;
    p = 100 * int'(spare_cur[i]) / int'(spare_init[i]);
    return (p > 100) ? 100 : p;
  endfunction

  function automatic int min_chip();
    int m;
    m = 0;
    for (int i = 1; i < `SPARE_CHIPS; i++) begin
      if (chip_pct(i) < chip_pct(m)) m = i;
    end
    return m;
  endfunction

  function automatic int life();
    longint a;
    a = longint'(counts.erase_avg);
    return (a >= TARGET) ? 0 : 100 - int'(100 * a / TARGET);
  endfunction

  function automatic bit exceeded();
    return chip_pct(min_chip()) < int'(spare_thr) || life() < int'(erase_thr);
  endfunction

  // lowest byte first
  task automatic put(int at, logic [63:0] v, int n);
    for (int i = 0; i < n; i++) exp_sec[at + i] = v[8*i +: 8];
  endtask

  // expected sector image, data or thresholds
  task automatic build(bit thr);
    logic [7:0]  ids [6];
    logic [15:0] si;
    logic [15:0] sc;
    logic [7:0]  sum;
    int          m;
    ids = '{`ID_SPARE, `ID_ERASE, `ID_ECC_TOTAL, `ID_ECC_CORR, `ID_READS, `ID_UDMA_CRC};
    m = min_chip();
    si = 16'h0000;
    sc = 16'h0000;
    sum = 8'h00;
    foreach (exp_sec[i]) exp_sec[i] = 8'h00;
    put(0, 64'h0004, 2);
    for (int n = 0; n < 6; n++) exp_sec[2 + 12*n] = ids[n];
    if (thr) begin
      exp_sec[3] = spare_thr;
      exp_sec[15] = erase_thr;
    end else begin
      for (int i = 0; i < `SPARE_CHIPS; i++) begin
        si += spare_init[i];
        sc += spare_cur[i];
      end
      put(3, 64'h0003, 2);
      exp_sec[5] = 8'(chip_pct(m));
      put(6, spare_init[m], 2);
      put(8, spare_cur[m], 2);
      put(10, si, 2);
      put(12, sc, 2);
      put(15, 64'h0002, 2);
      exp_sec[17] = 8'(life());
      put(18, counts.erase_total, 8);
      for (int n = 2; n < 6; n++) begin
        put(3 + 12*n, 64'h0002, 2);
        exp_sec[5 + 12*n] = 8'h64;
      end
      put(30, counts.ecc_total, 4);
      put(42, counts.ecc_corr, 4);
      put(54, counts.reads, 8);
      put(66, counts.udma_crc, 4);
      put(368, 64'h0003, 2);
      put(386, 64'h0002, 2);
    end
    for (int i = 0; i < 511; i++) sum += exp_sec[i];
    exp_sec[511] = -sum;
  endtask

  task automatic randomize_inputs();
    counts.erase_avg = $urandom_range(0, 120);
    counts.erase_total = {$urandom, $urandom};
    counts.ecc_total = $urandom;
    counts.ecc_corr = $urandom;
    counts.reads = {$urandom, $urandom};
    counts.udma_crc = $urandom;
    for (int i = 0; i < `SPARE_CHIPS; i++) begin
      spare_init[i] = 16'($urandom_range(0, 300));
      spare_cur[i] = 16'($urandom_range(0, 320));
    end
    spare_thr = 8'($urandom_range(0, 110));
    erase_thr = 8'($urandom_range(0, 110));
  endtask

  // ************************
  // compares and verdict
  // ************************
  task automatic check_val(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(string what, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_sector(string what);
    check_val({what, " count"}, 16'h0200, 16'(host_u.n_got));
    check_val({what, " last"}, 16'h01FF, 16'(host_u.last_at));
    check_val({what, " hold"}, 16'h0000, 16'(host_u.hold_err));
    for (int i = 0; i < 512; i++) begin
      check_val($sformatf("%s byte %0d", what, i), 16'(exp_sec[i]), 16'(host_u.sector[i]));
    end
  endtask

  task automatic status_check();
    logic ex;
    ex = exceeded();
    host_u.send(`CMD_RELIABILITY, `FEAT_RET_STATUS, `CYL_LO_OK, `CYL_HI_OK);
    check_bit("status valid", 1'b1, status_valid);
    check_val("status lo", 16'(ex ? `CYL_LO_BAD : `CYL_LO_OK), 16'(status_cyl_lo));
    check_val("status hi", 16'(ex ? `CYL_HI_BAD : `CYL_HI_OK), 16'(status_cyl_hi));
    @(negedge clk);
    check_bit("status end", 1'b0, status_valid);
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ************************
  // main sequence
  // ************************
  initial begin
    void'($urandom(32'h62F1A33E));
    srst = 1'b1;
    randomize_inputs();
    repeat (12) @(negedge clk);
    srst = 1'b0;
    check_bit("reset busy", 1'b0, busy);
    check_bit("reset valid", 1'b0, out_valid);
    check_val("reset lo", 16'h0000, 16'(status_cyl_lo));
    check_val("reset hi", 16'h0000, 16'(status_cyl_hi));
    check_bit("reset status", 1'b0, status_valid);
    check_bit("reset last", 1'b0, out_last);
    // status sweep, thresholds equal to and just above the values
    for (int k = 0; k < 40; k++) begin
      randomize_inputs();
      case (k % 4)
        0: begin
          spare_thr = 8'(chip_pct(min_chip()));
          erase_thr = 8'(life());
        end
        1: spare_thr = 8'(chip_pct(min_chip()) + 1);
        2: erase_thr = 8'(life() + 1);
        default: ;
      endcase
      status_check();
    end
    // malformed commands are ignored
    n0 = n_status;
    host_u.send(8'hB1, `FEAT_RET_STATUS, `CYL_LO_OK, `CYL_HI_OK);
    host_u.send(`CMD_RELIABILITY, `FEAT_RET_STATUS, 8'h4E, `CYL_HI_OK);
    host_u.send(`CMD_RELIABILITY, `FEAT_READ_THRESH, `CYL_LO_OK, 8'hC3);
    host_u.send(`CMD_RELIABILITY, 8'hD2, `CYL_LO_OK, `CYL_HI_OK);
    // let a wrongly answered last strobe reach the reply counter
    repeat (2) @(negedge clk);
    check_val("ignored replies", 16'(n0), 16'(n_status));
    check_bit("ignored busy", 1'b0, busy);
    // threshold sector, stalled, status request refused meanwhile
    randomize_inputs();
    build(1'b1);
    host_u.send(`CMD_RELIABILITY, `FEAT_READ_THRESH, `CYL_LO_OK, `CYL_HI_OK);
    check_bit("read busy", 1'b1, busy);
    fork
      host_u.collect(1'b1);
      host_u.send(`CMD_RELIABILITY, `FEAT_RET_STATUS, `CYL_LO_OK, `CYL_HI_OK);
    join
    check_val("refused reply", 16'(n0), 16'(n_status));
    check_bit("done busy", 1'b0, busy);
    check_sector("threshold");
    // data sectors, second with empty chip and worn-out life
    for (int j = 0; j < 2; j++) begin
      randomize_inputs();
      if (j == 1) begin
        spare_init[0] = 16'h0000;
        counts.erase_avg = 32'(TARGET);
      end
      build(1'b0);
      host_u.send(`CMD_RELIABILITY, `FEAT_READ_DATA, `CYL_LO_OK, `CYL_HI_OK);
      host_u.collect(j == 0);
      check_sector("data");
    end
    end_of_test();
  end
endmodule
